// *** shared/bcache_consts.svh ***
`ifndef BCACHE_CONSTS_SVH
`define BCACHE_CONSTS_SVH

// ==========================================================
// widths
`define BC_TAG_W          19
`define BC_INDEX_W        22
`define BC_SHAPE_W        9
`define BC_CNT_W          4
`define BC_DELAY_W        3
`define BC_HIST_W         8
`define BC_ADDR_W         12

// ==========================================================
// sequencing counts
`define BC_WRITE_CYCLES   10
`define BC_READ_CYCLES    2
`define BC_RATIO_MIN      4'h3
`define BC_RATIO_RESET    4'h3

// ==========================================================
// register map
`define BC_CTRL_OFF       12'h000
`define BC_STAT_OFF       12'h004
`define BC_CTRL_RESET     32'h0000_01FF
`define BC_CTRL_MASK      32'h0400_01FF
`define BC_CTRL_STRAM_BIT 26
`define BC_CTRL_SHAPE_LSB 0
`define BC_ST_BUSY_BIT    0
`define BC_ST_PERR_BIT    1
`define BC_ST_LOCK_BIT    2
`define BC_ST_VICTIM_BIT  3
`define BC_ST_RATIO_LSB   4
`define BC_ST_DELAY_LSB   8

`endif

// *** shared/bcache_pkg.sv ***
package bcache_pkg;
`include "bcache_consts.svh"

  typedef enum logic [1:0] {
    OP_PRIV_READ  = 2'b00,
    OP_PRIV_WRITE = 2'b01,
    OP_READ       = 2'b10,
    OP_FILL       = 2'b11
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } state_e;

  typedef struct packed {
    logic [`BC_TAG_W-1:0] addr;
    logic                 valid;
    logic                 shared;
    logic                 dirty;
    logic                 state_par;
    logic                 addr_par;
  } tag_bus_s;

  typedef struct packed {
    op_e                    kind;
    logic [`BC_INDEX_W-1:0] index;
    logic [`BC_TAG_W-1:0]   tag;
    logic                   valid;
    logic                   shared;
    logic                   dirty;
    logic                   lock;
    logic                   victim;
  } cmd_s;

  typedef struct packed {
    logic     hit;
    logic     parity_error;
    logic     lock_flag;
    tag_bus_s tag;
  } rsp_s;

  typedef struct packed {
    logic [3:0]             ratio;
    logic [`BC_DELAY_W-1:0] delay;
    logic [`BC_CNT_W-1:0]   cnt;
    logic                   primary;
    logic [`BC_HIST_W-1:0]  hist;
    logic                   mch;
  } clk_state_s;

  typedef struct packed {
    state_e               st;
    logic [`BC_CNT_W-1:0] cnt;
    cmd_s                 cmd;
    tag_bus_s             tag_out;
    logic [31:0]          ctrl;
    logic                 perr_sticky;
    logic                 lock_last;
    logic                 rsp_valid;
    rsp_s                 rsp;
    logic                 perr_pulse;
    logic [31:0]          prdata;
    logic                 pslverr;
  } ctl_state_s;

endpackage

// *** design/board_clock_gen.sv ***
`timescale 1ns/1ps
`include "bcache_consts.svh"

module board_clock_gen (
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_srst,
  // initialization straps
  input  wire logic [3:0]             i_system_irq_lines,
  input  wire logic                   i_machine_check_request,
  input  wire logic                   i_halt_request,
  input  wire logic                   i_power_fail_request,
  // board clocks
  output logic                        o_board_clock_primary_p,
  output logic                        o_board_clock_primary_n,
  output logic                        o_board_clock_delayed_p,
  output logic                        o_board_clock_delayed_n,
  // settings and normal-mode request
  output logic [3:0]                  o_ratio,
  output logic [`BC_DELAY_W-1:0]      o_delay,
  output logic                        o_machine_check
);

  bcache_pkg::clk_state_s q;
  bcache_pkg::clk_state_s d;

  // codes below the least ratio are not legal; run at the least one
  function automatic logic [3:0] clamp_ratio(input logic [3:0] r);
    clamp_ratio = (r < `BC_RATIO_MIN) ? `BC_RATIO_MIN : r;
  endfunction

  // ==========================================================
  // straps sampled on every clock edge while reset is high, so the last one counts
  always_comb begin
    d = q;
    if (i_srst) begin
      d.ratio   = clamp_ratio(i_system_irq_lines);
      d.delay   = {i_machine_check_request, i_halt_request, i_power_fail_request};
      // park at the period end so the first high phase after reset is full length
      d.cnt     = d.ratio - 4'h1;
      d.primary = 1'b0;
      d.hist    = '0;
      d.mch     = 1'b0;
    end else begin
      d.cnt     = (q.cnt >= q.ratio - 4'h1) ? '0 : q.cnt + 4'h1;
      d.primary = (d.cnt < (q.ratio >> 1));
      d.hist    = {q.hist[`BC_HIST_W-2:0], q.primary};
      d.mch     = i_machine_check_request;
    end
  end

  always_ff @(posedge i_clock) begin
    q <= d;
  end

  // ==========================================================
  // outputs
  assign o_board_clock_primary_p = q.primary;
  assign o_board_clock_primary_n = ~q.primary;
  assign o_board_clock_delayed_p = (q.delay == '0) ? q.primary : q.hist[q.delay - 3'h1];
  assign o_board_clock_delayed_n = ~o_board_clock_delayed_p;
  assign o_ratio                 = q.ratio;
  assign o_delay                 = q.delay;
  assign o_machine_check         = q.mch;

endmodule // board_clock_gen

// *** design/bcache_tag_ctrl.sv ***
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "bcache_consts.svh"

module bcache_tag_ctrl #(
  parameter int unsigned READ_CYCLES = `BC_READ_CYCLES
) (
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_srst,
  // apb slave
  input  wire logic [`BC_ADDR_W-1:0]     i_paddr,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [31:0]               i_pwdata,
  output logic                           o_pready,
  output logic [31:0]                    o_prdata,
  output logic                           o_pslverr,
  // command and response
  input  wire logic                      i_cmd_valid,
  input  wire bcache_pkg::cmd_s          i_cmd,
  output logic                           o_cmd_ready,
  output logic                           o_rsp_valid,
  output bcache_pkg::rsp_s               o_rsp,
  output logic                           o_tag_parity_error,
  // tag ram pins
  input  wire bcache_pkg::tag_bus_s      i_tag,
  output bcache_pkg::tag_bus_s           o_tag,
  output logic                           o_tag_oe_n,
  output logic [`BC_INDEX_W-1:0]         o_index,
  output logic                           o_tag_ram_oe,
  output logic                           o_tag_ram_we,
  output logic                           o_data_ram_oe,
  output logic                           o_data_ram_we,
  input  wire logic                      i_cache_strobe_polarity,
  // sync ram clocks
  output logic                           o_stram_clock_a,
  output logic                           o_stram_clock_b,
  // system signals
  input  wire logic                      i_external_lock_flag,
  output logic                           o_victim_flag,
  input  wire logic [3:0]                i_system_irq_lines,
  input  wire logic                      i_machine_check_request,
  input  wire logic                      i_halt_request,
  input  wire logic                      i_power_fail_request,
  output logic                           o_machine_check,
  // board clocks
  output logic                           o_board_clock_primary_p,
  output logic                           o_board_clock_primary_n,
  output logic                           o_board_clock_delayed_p,
  output logic                           o_board_clock_delayed_n
);

  localparam logic [`BC_CNT_W-1:0] READ_LAST  = `BC_CNT_W'(READ_CYCLES - 1);
  localparam logic [`BC_CNT_W-1:0] WRITE_LAST = `BC_CNT_W'(`BC_WRITE_CYCLES - 1);

  bcache_pkg::ctl_state_s q;
  bcache_pkg::ctl_state_s d;

  logic [3:0]             ratio;
  logic [`BC_DELAY_W-1:0] delay;
  logic                   oe_raw;
  logic                   we_raw;
  logic                   sys_op;
  logic                   priv_edge;
  logic                   state_bad;
  logic                   addr_bad;
  logic                   setup;
  logic                   access;
  logic [31:0]            stat_word;
  logic [`BC_SHAPE_W-1:0] shape;

  // ==========================================================
  // board clocks
  board_clock_gen u_clk (
    .i_clock                 (i_clock),
    .i_srst                  (i_srst),
    .i_system_irq_lines      (i_system_irq_lines),
    .i_machine_check_request (i_machine_check_request),
    .i_halt_request          (i_halt_request),
    .i_power_fail_request    (i_power_fail_request),
    .o_board_clock_primary_p (o_board_clock_primary_p),
    .o_board_clock_primary_n (o_board_clock_primary_n),
    .o_board_clock_delayed_p (o_board_clock_delayed_p),
    .o_board_clock_delayed_n (o_board_clock_delayed_n),
    .o_ratio                 (ratio),
    .o_delay                 (delay),
    .o_machine_check         (o_machine_check)
  );

  // ==========================================================
  // odd parity and write decode helpers
  function automatic logic odd_par(input logic [`BC_TAG_W-1:0] v);
    odd_par = ~^v;
  endfunction

  function automatic logic is_write(input bcache_pkg::op_e k);
    is_write = (k == bcache_pkg::OP_PRIV_WRITE) || (k == bcache_pkg::OP_FILL);
  endfunction

  // parity error on the bits seen at the pins, pins plus parity must be odd
  assign state_bad = ~^{i_tag.valid, i_tag.shared, i_tag.dirty, i_tag.state_par};
  assign addr_bad  = ~^{i_tag.addr, i_tag.addr_par};
  assign shape     = q.ctrl[`BC_CTRL_SHAPE_LSB +: `BC_SHAPE_W];

  // ==========================================================
  // apb decode
  assign setup  = i_psel & ~i_penable;
  assign access = i_psel & i_penable;

  always_comb begin
    stat_word                                         = '0;
    stat_word[`BC_ST_BUSY_BIT]                        = (q.st != bcache_pkg::ST_IDLE);
    stat_word[`BC_ST_PERR_BIT]                        = q.perr_sticky;
    stat_word[`BC_ST_LOCK_BIT]                        = q.lock_last;
    stat_word[`BC_ST_VICTIM_BIT]                      = o_victim_flag;
    stat_word[`BC_ST_RATIO_LSB +: 4]                  = ratio;
    stat_word[`BC_ST_DELAY_LSB +: `BC_DELAY_W]        = delay;
  end

  // ==========================================================
  // sequencer and registers
  always_comb begin
    d            = q;
    d.rsp_valid  = 1'b0;
    d.perr_pulse = 1'b0;

    // read data is captured in setup so that it comes from a flop
    if (setup) begin
      d.pslverr = 1'b0;
      case (i_paddr)
        `BC_CTRL_OFF: d.prdata = q.ctrl;
        `BC_STAT_OFF: d.prdata = stat_word;
        default: begin
          d.prdata  = '0;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (access && i_pwrite && (i_paddr == `BC_CTRL_OFF)) begin
      d.ctrl = i_pwdata & `BC_CTRL_MASK;
    end
    if (access && i_pwrite && (i_paddr == `BC_STAT_OFF) && i_pwdata[`BC_ST_PERR_BIT]) begin
      d.perr_sticky = 1'b0;
    end

    case (q.st)
      bcache_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          d.cmd                = i_cmd;
          d.cnt                = '0;
          d.tag_out.addr       = i_cmd.tag;
          d.tag_out.valid      = i_cmd.valid;
          d.tag_out.shared     = i_cmd.shared;
          d.tag_out.dirty      = i_cmd.dirty;
          d.tag_out.state_par  = ~^{i_cmd.valid, i_cmd.shared, i_cmd.dirty};
          d.tag_out.addr_par   = odd_par(i_cmd.tag);
          d.st                 = is_write(i_cmd.kind) ? bcache_pkg::ST_WRITE : bcache_pkg::ST_READ;
        end
      end
      bcache_pkg::ST_READ: begin
        d.cnt = q.cnt + `BC_CNT_W'(1);
        if (q.cnt == READ_LAST) begin
          d.st                   = bcache_pkg::ST_IDLE;
          d.rsp_valid            = 1'b1;
          d.rsp.tag              = i_tag;
          d.rsp.parity_error     = state_bad | addr_bad;
          d.rsp.hit              = i_tag.valid & ~(state_bad | addr_bad) & (i_tag.addr == q.cmd.tag);
          d.rsp.lock_flag        = 1'b0;
          d.perr_pulse           = state_bad | addr_bad;
        end
      end
      bcache_pkg::ST_WRITE: begin
        d.cnt = q.cnt + `BC_CNT_W'(1);
        if (q.cnt == WRITE_LAST) begin
          d.st                 = bcache_pkg::ST_IDLE;
          d.rsp_valid          = 1'b1;
          d.rsp.tag            = (q.cmd.kind == bcache_pkg::OP_FILL) ? i_tag : q.tag_out;
          d.rsp.parity_error   = 1'b0;
          // a fill reports whether the system marked the block valid
          d.rsp.hit            = (q.cmd.kind == bcache_pkg::OP_FILL) ? i_tag.valid : 1'b1;
          d.rsp.lock_flag      = (q.cmd.kind == bcache_pkg::OP_FILL) &
                                 i_external_lock_flag & q.cmd.lock;
          if (q.cmd.kind == bcache_pkg::OP_FILL) begin
            d.lock_last = i_external_lock_flag & q.cmd.lock;
          end
        end
      end
      default: d.st = bcache_pkg::ST_IDLE;
    endcase

    // set wins over a same-cycle software clear
    if (d.perr_pulse) begin
      d.perr_sticky = 1'b1;
    end

    if (i_srst) begin
      d      = '0;
      d.st   = bcache_pkg::ST_IDLE;
      d.ctrl = `BC_CTRL_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    q <= d;
  end

  // ==========================================================
  // strobes
  assign oe_raw = (q.st == bcache_pkg::ST_READ);
  assign we_raw = (q.st == bcache_pkg::ST_WRITE) && (q.cnt != '0) &&
                  shape[q.cnt - `BC_CNT_W'(1)];

  // polarity strap is static, so a plain xor is glitch-safe enough here
  assign o_tag_ram_oe  = oe_raw ^ i_cache_strobe_polarity;
  assign o_tag_ram_we  = we_raw ^ i_cache_strobe_polarity;
  assign o_data_ram_oe = oe_raw ^ i_cache_strobe_polarity;
  assign o_data_ram_we = we_raw ^ i_cache_strobe_polarity;

  assign o_tag      = q.tag_out;
  assign o_tag_oe_n = ~((q.st == bcache_pkg::ST_WRITE) && (q.cmd.kind == bcache_pkg::OP_PRIV_WRITE));
  assign o_index    = q.cmd.index;

  // ==========================================================
  // sync ram clock
  assign sys_op    = (q.cmd.kind == bcache_pkg::OP_READ) || (q.cmd.kind == bcache_pkg::OP_FILL);
  // private reads and writes get one pulse in their second cycle, while the index stands
  assign priv_edge = (q.cnt == `BC_CNT_W'(1));
  assign o_stram_clock_a = q.ctrl[`BC_CTRL_STRAM_BIT] && (q.st != bcache_pkg::ST_IDLE) &&
                           (sys_op ? o_board_clock_primary_p : priv_edge);
  assign o_stram_clock_b = o_stram_clock_a;

  // ==========================================================
  // remaining outputs
  assign o_victim_flag      = oe_raw && (q.cmd.kind == bcache_pkg::OP_READ) && q.cmd.victim;
  assign o_cmd_ready        = (q.st == bcache_pkg::ST_IDLE);
  assign o_rsp_valid        = q.rsp_valid;
  assign o_rsp              = q.rsp;
  assign o_tag_parity_error = q.perr_pulse;
  assign o_pready           = 1'b1;
  assign o_prdata           = q.prdata;
  assign o_pslverr          = q.pslverr;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  sequence s_write_start;
    o_cmd_ready && i_cmd_valid && is_write(i_cmd.kind);
  endsequence

  sequence s_read_start;
    o_cmd_ready && i_cmd_valid && !is_write(i_cmd.kind);
  endsequence

  a_we_first_low: assert property (s_write_start |=> !we_raw)
    else $error("write pulse high in first write cycle");
  a_we_shape_bit: assert property (s_write_start ##1 1'b1 |=> (we_raw == shape[0]))
    else $error("write pulse does not follow shape bit zero");
  a_read_oe_span: assert property (s_read_start |=> oe_raw [*2] ##1 !oe_raw)
    else $error("tag output enable not held through read");
  a_stram_gate: assert property (!q.ctrl[`BC_CTRL_STRAM_BIT] |-> !o_stram_clock_a && !o_stram_clock_b)
    else $error("stram clock running while disabled");
  a_strobe_polar: assert property (i_cache_strobe_polarity |-> (o_tag_ram_we == !we_raw))
    else $error("write strobe polarity wrong");
  a_state_parity: assert property (!o_tag_oe_n |-> ^{o_tag.valid, o_tag.shared, o_tag.dirty, o_tag.state_par})
    else $error("driven tag state parity not odd");
  a_addr_parity: assert property (!o_tag_oe_n |-> ^{o_tag.addr, o_tag.addr_par})
    else $error("driven tag address parity not odd");
  a_perr_raise: assert property (oe_raw && (q.cnt == READ_LAST) && (state_bad || addr_bad)
                                 |=> o_tag_parity_error && o_rsp_valid && q.perr_sticky)
    else $error("tag parity error not reported");
  a_lock_merge: assert property (o_rsp_valid && $past(q.cmd.kind == bcache_pkg::OP_FILL)
                                 |-> o_rsp.lock_flag == $past(i_external_lock_flag && q.cmd.lock))
    else $error("fill lock flag not merged");
  a_victim_only: assert property (o_victim_flag |-> oe_raw && q.cmd.victim)
    else $error("victim flag outside a victim read");

endmodule // bcache_tag_ctrl

// *** verification/tag_sram_model.sv ***
`timescale 1ns/1ps

module tag_sram_model (
  // clock and ram strobes, strobes active low
  input  wire logic                 i_clock,
  input  wire logic                 i_oe_n,
  input  wire logic                 i_we_n,
  // processor side of the tag bus
  input  wire logic                 i_tag_oe_n,
  input  wire bcache_pkg::tag_bus_s i_tag,
  // system logic during fills
  input  wire logic                 i_fill,
  input  wire logic                 i_fill_shared,
  input  wire logic                 i_corrupt,
  output bcache_pkg::tag_bus_s      o_tag
);
  bcache_pkg::tag_bus_s mem_q;
  bcache_pkg::tag_bus_s fill_v;
  bcache_pkg::tag_bus_s bus_v;

  always_comb begin
    fill_v           = mem_q;
    fill_v.valid     = 1'b1;
    fill_v.shared    = i_fill_shared;
    fill_v.dirty     = 1'b0;
    fill_v.state_par = ~^{1'b1, i_fill_shared, 1'b0};
    // a released bus shows the inverse so a stale sample cannot pass
    bus_v = i_oe_n ? ~mem_q : (mem_q ^ {23'h000000, i_corrupt});
  end

  assign o_tag = i_fill ? fill_v : bus_v;

  always_ff @(posedge i_clock) begin
    if (!i_we_n) begin
      mem_q <= i_tag_oe_n ? o_tag : i_tag;
    end
  end
endmodule // tag_sram_model

// *** verification/test_bcache_tag_ctrl.sv ***
`timescale 1ns/1ps
`include "bcache_consts.svh"

module test_bcache_tag_ctrl;
  // ==========================================================
  // signals
  localparam logic [18:0] TAG = 19'h5A5A5;
  localparam int RATIO = 9;
  localparam int DLY = 5;
  localparam int RC = 2;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [11:0] i_paddr = 12'h000;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, slverr, i_cmd_valid = 1'b0, o_cmd_ready, o_rsp_valid;
  bcache_pkg::cmd_s i_cmd = '0;
  bcache_pkg::rsp_s o_rsp, rsp;
  bcache_pkg::tag_bus_s i_tag, o_tag;
  logic o_tag_parity_error, o_tag_oe_n, o_tag_ram_oe, o_tag_ram_we, o_stram_clock_a, o_stram_clock_b;
  logic i_external_lock_flag = 1'b0, o_victim_flag, o_machine_check;
  logic [3:0] i_system_irq_lines = 4'h9;
  logic i_machine_check_request = 1'b1, i_halt_request = 1'b0, i_power_fail_request = 1'b1;
  logic o_board_clock_primary_p, o_board_clock_primary_n, o_board_clock_delayed_p, o_board_clock_delayed_n;
  logic i_fill = 1'b0, i_corrupt = 1'b0, perr, sbad, fbad, dbad, dro, drw, pol = 1'b1;
  logic [15:0] wev, oev, vicv, sv;
  logic [21:0] idx;
  int lat, bad_count = 0, comparisons = 0, cycles = 0;

  always #5 i_clock = ~i_clock;

  bcache_tag_ctrl #(.READ_CYCLES(RC)) u_bcache_tag_ctrl (
    .i_clock, .i_srst, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_rsp_valid, .o_rsp, .o_tag_parity_error,
    .i_tag, .o_tag, .o_tag_oe_n, .o_index(idx), .o_tag_ram_oe, .o_tag_ram_we, .o_data_ram_oe(dro),
    .o_data_ram_we(drw), .i_cache_strobe_polarity(pol), .o_stram_clock_a, .o_stram_clock_b,
    .i_external_lock_flag, .o_victim_flag, .i_system_irq_lines, .i_machine_check_request,
    .i_halt_request, .i_power_fail_request, .o_machine_check, .o_board_clock_primary_p,
    .o_board_clock_primary_n, .o_board_clock_delayed_p, .o_board_clock_delayed_n);

  tag_sram_model u_tag_sram_model (
    .i_clock, .i_oe_n(o_tag_ram_oe ^ ~pol), .i_we_n(o_tag_ram_we ^ ~pol), .i_tag_oe_n(o_tag_oe_n), .i_tag(o_tag),
    .i_fill, .i_fill_shared(1'b0), .i_corrupt, .o_tag(i_tag));

  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    slverr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  function automatic bcache_pkg::cmd_s mk(bcache_pkg::op_e k, logic vic, logic lk);
    mk = '0;
    mk.kind = k;
    mk.index = 22'h12345;
    mk.tag = TAG;
    mk.valid = 1'b1;
    mk.dirty = 1'b1;
    mk.lock = lk;
    mk.victim = vic;
  endfunction

  // samples strobes once per cycle from the cycle after acceptance
  task automatic run(input bcache_pkg::cmd_s c);
    wev = '0;
    oev = '0;
    vicv = '0;
    sv = '0;
    sbad = 1'b0;
    fbad = 1'b0;
    dbad = 1'b0;
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    #1;
    while (o_cmd_ready !== 1'b1) begin
      @(posedge i_clock);
      #1;
    end
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    for (lat = 0; lat < 15; lat++) begin
      #1;
      // asserted level is low while the polarity strap is high
      wev[lat] = o_tag_ram_we ^ pol;
      oev[lat] = o_tag_ram_oe ^ pol;
      vicv[lat] = o_victim_flag;
      sv[lat] = o_stram_clock_a;
      sbad |= (o_stram_clock_b !== o_stram_clock_a);
      dbad |= (dro !== o_tag_ram_oe) | (drw !== o_tag_ram_we);
      if (o_rsp_valid === 1'b1) break;
      fbad |= (c.kind inside {bcache_pkg::OP_READ, bcache_pkg::OP_FILL}) &&
              (o_stram_clock_a !== o_board_clock_primary_p);
      @(posedge i_clock);
    end
    rsp = o_rsp;
    perr = o_tag_parity_error;
  endtask

  // ==========================================================
  // scenarios
  task automatic chk_straps(input int r, input int dl);
    apb(1'b0, `BC_STAT_OFF, 32'h0);
    chk("ratio", r, rd[7:4]);
    chk("delay", dl, rd[10:8]);
  endtask

  task automatic t_regs();
    apb(1'b0, `BC_CTRL_OFF, 32'h0);
    chk("ctrl reset", `BC_CTRL_RESET, rd);
    chk_straps(RATIO, DLY);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 1'b1, slverr);
    apb(1'b1, `BC_CTRL_OFF, 32'hFFFF_FE55);
    apb(1'b0, `BC_CTRL_OFF, 32'h0);
    chk("ctrl", 32'h0400_0055, rd);
  endtask

  task automatic t_write_read();
    run(mk(bcache_pkg::OP_PRIV_WRITE, 1'b0, 1'b0));
    chk("write latency", 10, lat);
    chk("write pulse", {9'h055, 1'b0}, wev[9:0]);
    chk("stram write", 3'b010, sv[2:0]);
    chk("index", 22'h12345, idx);
    chk("data we", 1'b0, dbad);
    run(mk(bcache_pkg::OP_PRIV_READ, 1'b0, 1'b0));
    chk("read latency", RC, lat);
    chk("tag oe", 2'b11, oev[1:0]);
    chk("read hit", 1'b1, rsp.hit);
    chk("tag addr", TAG, rsp.tag.addr);
    chk("addr par", ~^TAG, rsp.tag.addr_par);
    chk("state par", ~^3'b101, rsp.tag.state_par);
    chk("no perr", 1'b0, perr);
    chk("stram", 3'b010, sv[2:0]);
    chk("stram copy", 1'b0, sbad);
    chk("data oe", 1'b0, dbad);
    i_corrupt <= 1'b1;
    run(mk(bcache_pkg::OP_PRIV_READ, 1'b0, 1'b0));
    i_corrupt <= 1'b0;
    chk("perr pulse", 1'b1, perr);
    chk("rsp perr", 1'b1, rsp.parity_error);
    apb(1'b0, `BC_STAT_OFF, 32'h0);
    chk("perr sticky", 1'b1, rd[`BC_ST_PERR_BIT]);
    apb(1'b1, `BC_STAT_OFF, 32'h0000_0002);
    apb(1'b0, `BC_STAT_OFF, 32'h0);
    chk("perr clear", 1'b0, rd[`BC_ST_PERR_BIT]);
  endtask

  task automatic t_fill_victim();
    i_fill <= 1'b1;
    i_external_lock_flag <= 1'b1;
    run(mk(bcache_pkg::OP_FILL, 1'b0, 1'b1));
    chk("fill hit", 1'b1, rsp.hit);
    chk("lock and", 1'b1, rsp.lock_flag);
    chk("stram fill", 1'b0, fbad);
    i_external_lock_flag <= 1'b0;
    run(mk(bcache_pkg::OP_FILL, 1'b0, 1'b1));
    chk("lock and", 1'b0, rsp.lock_flag);
    i_external_lock_flag <= 1'b1;
    run(mk(bcache_pkg::OP_FILL, 1'b0, 1'b0));
    chk("lock own", 1'b0, rsp.lock_flag);
    i_fill <= 1'b0;
    run(mk(bcache_pkg::OP_READ, 1'b1, 1'b0));
    chk("victim", 1'b1, vicv[0]);
    chk("stram read", 1'b0, fbad);
    run(mk(bcache_pkg::OP_READ, 1'b0, 1'b0));
    chk("no victim", 1'b0, vicv[1:0]);
    apb(1'b1, `BC_CTRL_OFF, 32'h0000_0055);
    run(mk(bcache_pkg::OP_PRIV_READ, 1'b0, 1'b0));
    chk("stram off", 1'b0, sv);
  endtask

  // second reset mid-run: new straps, strobes switched to active high
  task automatic t_reset();
    @(posedge i_clock);
    i_srst <= 1'b1;
    pol <= 1'b0;
    i_system_irq_lines <= 4'hC;
    i_machine_check_request <= 1'b0;
    i_halt_request <= 1'b1;
    i_power_fail_request <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    i_system_irq_lines <= 4'h5;
    i_halt_request <= 1'b0;
    apb(1'b0, `BC_CTRL_OFF, 32'h0);
    chk("ctrl reset", `BC_CTRL_RESET, rd);
    chk_straps(12, 3);
    run(mk(bcache_pkg::OP_PRIV_WRITE, 1'b0, 1'b0));
    chk("write pulse high", {9'h1FF, 1'b0}, wev[9:0]);
    run(mk(bcache_pkg::OP_PRIV_READ, 1'b0, 1'b0));
    chk("tag oe high", 3'b011, oev[2:0]);
    chk("hit high", 1'b1, rsp.hit);
  endtask

  task automatic t_clock(input int r, input int dl);
    logic [17:0] pv, dv, nv, ev, ed;
    while (o_board_clock_primary_p !== 1'b0) begin
      @(posedge i_clock);
      #1;
    end
    while (o_board_clock_primary_p !== 1'b1) begin
      @(posedge i_clock);
      #1;
    end
    for (int k = 0; k < 18; k++) begin
      pv[k] = o_board_clock_primary_p;
      dv[k] = o_board_clock_delayed_p;
      nv[k] = (o_board_clock_primary_n !== ~pv[k]) | (o_board_clock_delayed_n !== ~dv[k]);
      ev[k] = (k % r) < (r / 2);
      ed[k] = ((k + 8 * r - dl) % r) < (r / 2);
      @(posedge i_clock);
      #1;
    end
    chk("primary", ev, pv);
    chk("delayed", ed, dv);
    chk("differential", 1'b0, nv);
    @(posedge i_clock);
    i_machine_check_request <= 1'b1;
    #1 chk("mch early", 1'b0, o_machine_check);
    @(posedge i_clock);
    #1 chk("mch", 1'b1, o_machine_check);
  endtask

  // ==========================================================
  // run
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge i_clock);
    // straps move after reset; the latched settings must not follow
    i_srst <= 1'b0;
    i_machine_check_request <= 1'b0;
    i_halt_request <= 1'b1;
    i_system_irq_lines <= 4'h3;
    t_regs();
    t_write_read();
    t_fill_victim();
    t_clock(RATIO, DLY);
    t_reset();
    t_clock(12, 3);
    give_verdict();
  end
endmodule // test_bcache_tag_ctrl
